// ### include/pw_pkg.sv
package pw_pkg;
    localparam int NFLOW     = 4;
    localparam int FLOW_W    = 2;
    localparam int SEQ_W     = 16;
    localparam int SID_W     = 32;
    localparam int TS_W      = 32;
    localparam int BUF_DEPTH = 32;
    localparam int IDX_W     = 5;
    localparam int LEN_W     = 6;
    localparam int TSC_W     = 8;
    localparam int SY_W      = 5;

    localparam logic [LEN_W-1:0]  RA_FULL   = 6'h20;
    localparam logic [LEN_W-1:0]  LEN_ONE   = 6'h01;
    localparam logic [TSC_W-1:0]  TS_LAST   = 8'hbb;
    localparam logic [TSC_W-1:0]  TSC_ONE   = 8'h01;
    localparam logic [SEQ_W-1:0]  SEQ_ONE   = 16'h0001;
    localparam logic [FLOW_W-1:0] FLOW_RSVD = 2'h0;
    localparam logic [7:0]        NULL_B0   = 8'h47;
    localparam logic [7:0]        NULL_B1   = 8'h1f;
    localparam logic [7:0]        NULL_B2   = 8'hff;
    localparam logic [7:0]        NULL_B3   = 8'h10;
    localparam logic [7:0]        NULL_FILL = 8'hff;
    localparam logic [47:0]       SYNC_DA   = 48'h01e0_2f00_0001;
    localparam logic [SY_W-1:0]   SY_LOAD   = 5'h11;
    localparam logic [SY_W-1:0]   SY_BYTES  = 5'h04;
    localparam logic [SY_W-1:0]   SY_ONE    = 5'h01;

    typedef enum logic [1:0] {FMT_STREAM, FMT_MPEG, FMT_MULTI} pw_fmt_t;

    typedef struct packed {
        logic [7:0]        data;
        logic              first;
        logic              last;
        logic              pstart;
        logic              pend;
        logic [FLOW_W-1:0] flow;
        logic [SEQ_W-1:0]  seq;
    } ds_beat_t;
endpackage : pw_pkg

// ### include/pw_if.sv
`timescale 1ns/1ns
interface pw_if;
    logic                     ds_valid;
    logic                     ds_ready;
    pw_pkg::ds_beat_t         ds_beat;
    logic [pw_pkg::SID_W-1:0] ds_session;
    logic                     us_valid;
    logic                     us_ready;
    logic [7:0]               us_data;
    logic [pw_pkg::FLOW_W-1:0] us_flow;
    logic                     us_last;

    modport core_mp (
        output ds_valid,
        input  ds_ready,
        output ds_beat,
        output ds_session,
        input  us_valid,
        output us_ready,
        input  us_data,
        input  us_flow,
        input  us_last
    );

    modport node_mp (
        input  ds_valid,
        output ds_ready,
        input  ds_beat,
        input  ds_session,
        output us_valid,
        input  us_ready,
        output us_data,
        output us_flow,
        output us_last
    );
endinterface : pw_if

// ### rtl/core_end.sv
`timescale 1ns/1ns
module core_end (
    input  wire logic                      ref_clk_i,
    input  wire logic                      rst_i,
    pw_if.core_mp                          link,
    input  wire pw_pkg::pw_fmt_t           fmt_i,
    input  wire logic [pw_pkg::SID_W-1:0]  session_i,
    input  wire logic                      tx_valid_i,
    input  wire logic [7:0]                tx_data_i,
    input  wire logic                      tx_first_i,
    input  wire logic                      tx_last_i,
    input  wire logic [pw_pkg::FLOW_W-1:0] tx_flow_i,
    input  wire logic                      tx_pstart_i,
    input  wire logic                      tx_pend_i,
    output logic                           tx_ready_o,
    output logic                           rx_valid_o,
    output logic [7:0]                     rx_data_o,
    output logic [pw_pkg::FLOW_W-1:0]      rx_flow_o,
    output logic                           rx_last_o,
    input  wire logic                      rx_ready_i
);
    import pw_pkg::*;

    typedef struct packed {
        logic                         locked;
        pw_fmt_t                      fmt;
        logic [SID_W-1:0]             sid;
        logic [NFLOW-1:0][SEQ_W-1:0]  seqs;
        logic                         ds_valid;
        ds_beat_t                     beat;
        logic [FLOW_W-1:0]            cur_flow;
        logic [SEQ_W-1:0]             cur_seq;
        logic                         tx_rdy;
        logic                         rx_valid;
        logic [7:0]                   rx_data;
        logic [FLOW_W-1:0]            rx_flow;
        logic                         rx_last;
        logic                         rx_rdy;
    } state_t;

    state_t            q;
    state_t            d;
    logic              strm;
    logic [FLOW_W-1:0] fl;
    logic [SEQ_W-1:0]  sq;

    always_comb
    begin
        d    = q;
        strm = q.fmt == FMT_STREAM;
        fl   = q.cur_flow;
        sq   = q.cur_seq;
        // Type fixed once per session, caught after reset release
        if (!q.locked)
        begin
            d.locked = 1'b1;
            d.fmt    = fmt_i;
            d.sid    = session_i;
        end
        if (q.ds_valid && link.ds_ready)
            d.ds_valid = 1'b0;
        if (tx_valid_i && q.tx_rdy)
        begin
            if (tx_first_i)
            begin
                fl          = strm ? tx_flow_i : FLOW_RSVD;
                sq          = q.seqs[fl];
                d.seqs[fl]  = q.seqs[fl] + SEQ_ONE;
                d.cur_flow  = fl;
                d.cur_seq   = sq;
            end
            d.ds_valid    = 1'b1;
            d.beat.data   = tx_data_i;
            d.beat.first  = tx_first_i;
            d.beat.last   = tx_last_i;
            d.beat.pstart = tx_pstart_i && strm;
            d.beat.pend   = tx_pend_i && strm;
            d.beat.flow   = fl;
            d.beat.seq    = sq;
        end
        // Registered ready costs half rate but keeps outputs on flops
        d.tx_rdy = !d.ds_valid && d.locked;
        if (q.rx_valid && rx_ready_i)
            d.rx_valid = 1'b0;
        if (link.us_valid && q.rx_rdy)
        begin
            d.rx_valid = 1'b1;
            d.rx_data  = link.us_data;
            d.rx_flow  = link.us_flow;
            d.rx_last  = link.us_last;
        end
        d.rx_rdy = !d.rx_valid;
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
            q <= '0;
        else
            q <= d;
    end

    assign link.ds_valid   = q.ds_valid;
    assign link.ds_beat    = q.beat;
    assign link.ds_session = q.sid;
    assign link.us_ready   = q.rx_rdy;
    assign tx_ready_o      = q.tx_rdy;
    assign rx_valid_o      = q.rx_valid;
    assign rx_data_o       = q.rx_data;
    assign rx_flow_o       = q.rx_flow;
    assign rx_last_o       = q.rx_last;
endmodule : core_end

// ### rtl/remote_node_end.sv
`timescale 1ns/1ns
module remote_node_end (
    input  wire logic                      ref_clk_i,
    input  wire logic                      rst_i,
    pw_if.node_mp                          link,
    input  wire pw_pkg::pw_fmt_t           fmt_i,
    input  wire logic [pw_pkg::SID_W-1:0]  session_i,
    input  wire logic [pw_pkg::TS_W-1:0]   sync_ts_i,
    input  wire logic                      rf_ready_i,
    output logic                           rf_valid_o,
    output logic [7:0]                     rf_data_o,
    input  wire logic                      qos_ready_i,
    output logic                           qos_valid_o,
    output logic [7:0]                     qos_data_o,
    output logic [pw_pkg::FLOW_W-1:0]      qos_flow_o,
    output logic                           qos_last_o,
    input  wire logic                      us_valid_i,
    input  wire logic [7:0]                us_data_i,
    input  wire logic [pw_pkg::FLOW_W-1:0] us_flow_i,
    input  wire logic                      us_last_i,
    output logic                           us_ready_o,
    input  wire logic                      join_valid_i,
    input  wire logic [31:0]               join_group_i,
    output logic                           mcast_join_o,
    output logic [31:0]                    mcast_group_o
);
    import pw_pkg::*;
    typedef struct packed {
        logic                                   locked;
        pw_fmt_t                                fmt;
        logic [SID_W-1:0]                       sid;
        ds_beat_t [1:0]                         fb;
        logic [1:0]                             fb_cnt;
        logic                                   ds_rdy;
        logic [NFLOW-1:0][BUF_DEPTH-1:0][7:0]   ra_mem;
        logic [NFLOW-1:0][LEN_W-1:0]            ra_len;
        logic [NFLOW-1:0]                       ra_act;
        logic [NFLOW-1:0]                       ra_done;
        logic [NFLOW-1:0]                       ra_known;
        logic [NFLOW-1:0][SEQ_W-1:0]            ra_exp;
        logic                                   dr_busy;
        logic [FLOW_W-1:0]                      dr_flow;
        logic [IDX_W-1:0]                       dr_idx;
        logic                                   qos_valid;
        logic [7:0]                             qos_data;
        logic [FLOW_W-1:0]                      qos_flow;
        logic                                   qos_last;
        logic [SEQ_W-1:0]                       mp_exp;
        logic                                   mp_known;
        logic                                   mp_drop;
        logic [TSC_W-1:0]                       ts_cnt;
        logic                                   ts_null;
        logic                                   rf_valid;
        logic [7:0]                             rf_data;
        logic [39:0]                            sh;
        logic [SY_W-1:0]                        sy_cnt;
        logic                                   us_valid;
        logic [7:0]                             us_data;
        logic [FLOW_W-1:0]                      us_flow;
        logic                                   us_last;
        logic                                   us_rdy;
        logic                                   mc_join;
        logic [31:0]                            mc_group;
    } state_t;
    function automatic logic [7:0] null_byte(input logic [TSC_W-1:0] c);
        case (c)
            8'h00:   null_byte = NULL_B0;
            8'h01:   null_byte = NULL_B1;
            8'h02:   null_byte = NULL_B2;
            8'h03:   null_byte = NULL_B3;
            default: null_byte = NULL_FILL;
        endcase
    endfunction : null_byte
    state_t            q;
    state_t            d;
    ds_beat_t          hd;
    logic              pop;
    logic              mpeg;
    logic              drop;
    logic              data_av;
    logic              null_now;
    logic              act;
    logic [7:0]        b;
    logic [FLOW_W-1:0] f;
    logic [FLOW_W-1:0] sel;
    logic [LEN_W-1:0]  len;
    logic [LEN_W-1:0]  nidx;
    logic [1:0]        cnt;
    logic [SEQ_W-1:0]  diff;
    logic [SY_W-1:0]   syi;
    always_comb
    begin
        d        = q;
        hd       = q.fb[0];
        pop      = 1'b0;
        null_now = 1'b0;
        act      = 1'b0;
        b        = 8'h00;
        f        = hd.flow;
        sel      = '0;
        len      = '0;
        nidx     = '0;
        syi      = q.sy_cnt - SY_ONE;
        if (!q.locked)
        begin
            d.locked = 1'b1;
            d.fmt    = fmt_i;
            d.sid    = session_i;
        end
        mpeg    = q.locked && (q.fmt != FMT_STREAM);
        diff    = hd.seq - q.mp_exp;
        drop    = hd.first ? (q.mp_known && diff[SEQ_W-1]) : q.mp_drop;
        data_av = mpeg && (|q.fb_cnt) && !drop;
        if (mpeg && (|q.fb_cnt) && drop)
        begin
            pop       = 1'b1;
            d.mp_drop = 1'b1;
        end
        if (!q.rf_valid || rf_ready_i)
        begin
            null_now   = (q.ts_cnt == '0) ? !data_av : q.ts_null;
            d.rf_valid = null_now || data_av;
            if (null_now || data_av)
            begin
                b = null_now ? null_byte(q.ts_cnt) : hd.data;
                if (!null_now)
                begin
                    pop = 1'b1;
                    if (hd.first)
                    begin
                        d.mp_drop  = 1'b0;
                        d.mp_exp   = hd.seq + SEQ_ONE;
                        d.mp_known = 1'b1;
                    end
                    if (q.sy_cnt != '0)
                    begin
                        if (q.sy_cnt <= SY_BYTES)
                            b = sync_ts_i[8*syi[1:0] +: 8];
                        d.sy_cnt = syi;
                    end
                    else if ({q.sh, b} == SYNC_DA)
                        d.sy_cnt = SY_LOAD;
                    d.sh = {q.sh[31:0], b};
                end
                d.rf_data  = b;
                d.ts_null  = null_now;
                d.ts_cnt   = (q.ts_cnt == TS_LAST) ? '0 : q.ts_cnt + TSC_ONE;
            end
        end
        if (!mpeg && q.locked && (|q.fb_cnt) && !q.ra_done[f])
        begin
            pop = 1'b1;
            act = q.ra_act[f];
            if (hd.first)
            begin
                if (q.ra_known[f] && (hd.seq != q.ra_exp[f]))
                    act = 1'b0;
                d.ra_exp[f]   = hd.seq + SEQ_ONE;
                d.ra_known[f] = 1'b1;
            end
            len = hd.pstart ? '0 : q.ra_len[f];
            if (hd.pstart)
                act = 1'b1;
            if (act)
            begin
                d.ra_mem[f][len[IDX_W-1:0]] = hd.data;
                len = len + LEN_ONE;
                if (hd.pend)
                    d.ra_done[f] = 1'b1;
                if (hd.pend || (len == RA_FULL))
                    act = 1'b0;
            end
            d.ra_len[f] = len;
            d.ra_act[f] = act;
        end
        for (int i = 0; i < NFLOW; i++)
            if (q.ra_done[i])
                sel = i[FLOW_W-1:0];
        if (q.qos_valid && qos_ready_i)
            d.qos_valid = 1'b0;
        if (!q.dr_busy && (|q.ra_done))
        begin
            d.dr_busy = 1'b1;
            d.dr_flow = sel;
            d.dr_idx  = '0;
        end
        else if (q.dr_busy && (!q.qos_valid || qos_ready_i))
        begin
            nidx                 = {1'b0, q.dr_idx} + LEN_ONE;
            d.qos_valid          = 1'b1;
            d.qos_data           = q.ra_mem[q.dr_flow][q.dr_idx];
            d.qos_flow           = q.dr_flow;
            d.qos_last           = nidx == q.ra_len[q.dr_flow];
            d.dr_idx             = nidx[IDX_W-1:0];
            d.dr_busy            = !d.qos_last;
            d.ra_done[q.dr_flow] = !d.qos_last;
        end
        // Two-entry buffer; wrong sessions are consumed and dropped
        cnt = q.fb_cnt;
        if (pop)
        begin
            d.fb[0] = q.fb[1];
            cnt     = cnt - 2'h1;
        end
        if (link.ds_valid && q.ds_rdy && q.locked && (link.ds_session == q.sid))
        begin
            d.fb[cnt[0]] = link.ds_beat;
            cnt          = cnt + 2'h1;
        end
        d.fb_cnt = cnt;
        d.ds_rdy = cnt != 2'h2;
        if (q.us_valid && link.us_ready)
            d.us_valid = 1'b0;
        if (us_valid_i && q.us_rdy)
        begin
            d.us_valid = 1'b1;
            d.us_data  = us_data_i;
            d.us_flow  = (q.fmt == FMT_STREAM) ? us_flow_i : FLOW_RSVD;
            d.us_last  = us_last_i;
        end
        d.us_rdy = !d.us_valid && q.locked;
        d.mc_join = q.mc_join || join_valid_i;
        if (join_valid_i)
            d.mc_group = join_group_i;
    end
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
            q <= '0;
        else
            q <= d;
    end
    assign link.ds_ready = q.ds_rdy;
    assign link.us_valid = q.us_valid;
    assign link.us_data  = q.us_data;
    assign link.us_flow  = q.us_flow;
    assign link.us_last  = q.us_last;
    assign rf_valid_o    = q.rf_valid;
    assign rf_data_o     = q.rf_data;
    assign qos_valid_o   = q.qos_valid;
    assign qos_data_o    = q.qos_data;
    assign qos_flow_o    = q.qos_flow;
    assign qos_last_o    = q.qos_last;
    assign us_ready_o    = q.us_rdy;
    assign mcast_join_o  = q.mc_join;
    assign mcast_group_o = q.mc_group;
endmodule : remote_node_end

// ### tb/pw_monitor.sv
`timescale 1ns/1ns
module pw_monitor (
    input wire logic                      ref_clk_i,
    input wire logic                      rst_i,
    input wire logic                      ds_valid,
    input wire logic                      ds_ready,
    input wire pw_pkg::ds_beat_t          ds_beat,
    input wire logic [pw_pkg::SID_W-1:0]  ds_session,
    input wire logic                      us_valid,
    input wire logic                      us_ready,
    input wire logic [7:0]                us_data,
    input wire logic [pw_pkg::FLOW_W-1:0] us_flow,
    input wire logic                      us_last
);
    import pw_pkg::*;

    logic [NFLOW-1:0]  known_q;
    logic [SEQ_W-1:0]  last_seq_q [NFLOW];
    logic              in_pkt_q;
    logic [FLOW_W-1:0] pkt_flow_q;
    logic [SEQ_W-1:0]  pkt_seq_q;
    logic              take;

    assign take = ds_valid && ds_ready;

    // Open tunnel packet and last stamped sequence per flow
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            known_q  <= '0;
            in_pkt_q <= 1'b0;
        end
        else if (take)
        begin
            known_q[ds_beat.flow]    <= 1'b1;
            last_seq_q[ds_beat.flow] <= ds_beat.seq;
            in_pkt_q                 <= !ds_beat.last;
            pkt_flow_q               <= ds_beat.flow;
            pkt_seq_q                <= ds_beat.seq;
        end
    end

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    a_ds_hold: assert property (ds_valid && !ds_ready |=> ds_valid && $stable(ds_beat) && $stable(ds_session))
        else $error("downstream beat changed before it was taken");
    a_us_hold: assert property (us_valid && !us_ready |=> us_valid && $stable({us_data, us_flow, us_last}))
        else $error("upstream beat changed before it was taken");
    a_ds_gap: assert property (take |=> !ds_valid)
        else $error("downstream beat repeated right after handshake");
    a_us_gap: assert property (us_valid && us_ready |=> !us_valid)
        else $error("upstream beat repeated right after handshake");
    a_beat_flow: assert property (take && in_pkt_q |-> !ds_beat.first && ds_beat.flow == pkt_flow_q
                                  && ds_beat.seq == pkt_seq_q)
        else $error("flow or sequence changed inside a tunnel packet");
    a_pkt_first: assert property (take && !in_pkt_q |-> ds_beat.first)
        else $error("tunnel packet did not open with a first beat");
    a_seq_step: assert property (take && ds_beat.first && known_q[ds_beat.flow]
                                 |-> ds_beat.seq == last_seq_q[ds_beat.flow] + SEQ_ONE)
        else $error("tunnel sequence did not step by one");
    a_reset_quiet: assert property ($fell(rst_i) |-> !ds_valid && !us_valid && !ds_ready && !us_ready)
        else $error("link active at reset release");
endmodule : pw_monitor

// ### tb/test_rpd_downstream_pseudowire_path.sv
`timescale 1ns/1ns
module test_rpd_downstream_pseudowire_path;
    import pw_pkg::*;

    localparam logic [SID_W-1:0] SID = 32'h0000_5a3c;

    logic              ref_clk_i    = 1'b0;
    logic              rst_i        = 1'b1;
    pw_fmt_t           fmt_sel      = FMT_STREAM;
    logic [TS_W-1:0]   sync_ts_i    = 32'h0000_0000;
    logic              tx_valid_i   = 1'b0;
    logic [7:0]        tx_data_i    = 8'h00;
    logic              tx_first_i   = 1'b0;
    logic              tx_last_i    = 1'b0;
    logic [FLOW_W-1:0] tx_flow_i    = 2'h0;
    logic              tx_pstart_i  = 1'b0;
    logic              tx_pend_i    = 1'b0;
    logic              rx_ready_i   = 1'b0;
    logic              rf_ready_i   = 1'b0;
    logic              qos_ready_i  = 1'b0;
    logic              us_valid_i   = 1'b0;
    logic [7:0]        us_data_i    = 8'h00;
    logic [FLOW_W-1:0] us_flow_i    = 2'h0;
    logic              us_last_i    = 1'b0;
    logic              join_valid_i = 1'b0;
    logic [31:0]       join_group_i = 32'h0000_0000;
    logic              tx_ready_o, rx_valid_o, rx_last_o, rf_valid_o, qos_valid_o, qos_last_o, us_ready_o, mcast_join_o;
    logic [7:0]        rx_data_o, rf_data_o, qos_data_o;
    logic [FLOW_W-1:0] rx_flow_o, qos_flow_o;
    logic [31:0]       mcast_group_o, jg;
    logic [TS_W-1:0]   ts;
    logic [7:0]        b;
    int                n_fail = 0;
    int                comparisons = 0;
    int                seed = 69;
    int                ri = 0;
    bit                dslot, jv;
    logic [8:0]        exp_q [NFLOW][$];
    logic [7:0]        cur_q [NFLOW][$];
    logic [7:0]        pay [$];
    logic [7:0]        rq [$];
    logic [10:0]       uq [$];
    logic [31:0]       jq [$];

    always #4 ref_clk_i = ~ref_clk_i;

    pw_if link ();
    core_end u_core_end (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .link(link), .fmt_i(fmt_sel), .session_i(SID),
        .tx_valid_i(tx_valid_i), .tx_data_i(tx_data_i), .tx_first_i(tx_first_i), .tx_last_i(tx_last_i),
        .tx_flow_i(tx_flow_i), .tx_pstart_i(tx_pstart_i), .tx_pend_i(tx_pend_i), .tx_ready_o(tx_ready_o),
        .rx_valid_o(rx_valid_o), .rx_data_o(rx_data_o), .rx_flow_o(rx_flow_o), .rx_last_o(rx_last_o),
        .rx_ready_i(rx_ready_i));
    remote_node_end u_remote_node_end (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .link(link), .fmt_i(fmt_sel),
        .session_i(SID), .sync_ts_i(sync_ts_i), .rf_ready_i(rf_ready_i), .rf_valid_o(rf_valid_o),
        .rf_data_o(rf_data_o), .qos_ready_i(qos_ready_i), .qos_valid_o(qos_valid_o), .qos_data_o(qos_data_o),
        .qos_flow_o(qos_flow_o), .qos_last_o(qos_last_o), .us_valid_i(us_valid_i), .us_data_i(us_data_i),
        .us_flow_i(us_flow_i), .us_last_i(us_last_i), .us_ready_o(us_ready_o), .join_valid_i(join_valid_i),
        .join_group_i(join_group_i), .mcast_join_o(mcast_join_o), .mcast_group_o(mcast_group_o));
    pw_monitor u_pw_monitor (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .ds_valid(link.ds_valid),
        .ds_ready(link.ds_ready), .ds_beat(link.ds_beat), .ds_session(link.ds_session), .us_valid(link.us_valid),
        .us_ready(link.us_ready), .us_data(link.us_data), .us_flow(link.us_flow), .us_last(link.us_last));

    task automatic miss(input string what, input logic [63:0] e, input logic [63:0] g);
        n_fail++;
        $display("[FAIL] %0t %s exp %h got %h", $time, what, e, g);
    endtask : miss
    task automatic chk_byte(input logic [7:0] e, input logic [7:0] g);
        comparisons++;
        if (g !== e) miss("byte", 64'(e), 64'(g));
    endtask : chk_byte
    task automatic chk_beat(input logic [10:0] e, input logic [10:0] g);
        comparisons++;
        if (g !== e) miss("beat", 64'(e), 64'(g));
    endtask : chk_beat
    task automatic chk_grp(input logic [32:0] e, input logic [32:0] g);
        comparisons++;
        if (g !== e) miss("group", 64'(e), 64'(g));
    endtask : chk_grp

    task automatic test_done;
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : test_done

    task automatic do_reset(input pw_fmt_t f);
        rst_i   <= 1'b1;
        fmt_sel <= f;
        repeat (4) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        repeat (2) @(posedge ref_clk_i);
    endtask : do_reset

    // Masks mark inner packet bounds by byte position in the tunnel packet
    task automatic tunnel(input logic [1:0] f, input int n, input logic [31:0] ps_m, input logic [31:0] pe_m);
        for (int i = 0; i < n; i++)
        begin
            b = (pay.size() > 0) ? pay.pop_front() : 8'($random(seed));
            if (i < 32 && ps_m[i]) cur_q[f].delete();
            cur_q[f].push_back(b);
            if (i < 32 && pe_m[i])
                foreach (cur_q[f][k]) exp_q[f].push_back({k == cur_q[f].size() - 1, cur_q[f][k]});
            tx_valid_i  <= 1'b1;
            tx_data_i   <= b;
            tx_flow_i   <= f;
            tx_first_i  <= (i == 0);
            tx_last_i   <= (i == n - 1);
            tx_pstart_i <= (i < 32) && ps_m[i];
            tx_pend_i   <= (i < 32) && pe_m[i];
            @(posedge ref_clk_i);
            while (tx_ready_o !== 1'b1) @(posedge ref_clk_i);
        end
        tx_valid_i <= 1'b0;
        @(posedge ref_clk_i);
    endtask : tunnel

    task automatic us_send(input logic [7:0] d, input logic [1:0] f, input logic l);
        us_valid_i <= 1'b1;
        us_data_i  <= d;
        us_flow_i  <= f;
        us_last_i  <= l;
        uq.push_back({(fmt_sel == FMT_STREAM) ? f : FLOW_RSVD, l, d});
        @(posedge ref_clk_i);
        while (us_ready_o !== 1'b1) @(posedge ref_clk_i);
        us_valid_i <= 1'b0;
        @(posedge ref_clk_i);
    endtask : us_send

    task automatic drain;
        int pend;
        for (int k = 0; k < 3000; k++)
        begin
            pend = rq.size() + uq.size() + jq.size();
            foreach (exp_q[f]) pend += exp_q[f].size();
            if (pend == 0) break;
            @(posedge ref_clk_i);
        end
        chk_grp(33'h0_0000_0000, 33'(pend));
    endtask : drain

    // Stalls on every receiving side
    always @(posedge ref_clk_i)
    begin
        rf_ready_i  <= 1'($random(seed));
        qos_ready_i <= 1'($random(seed));
        rx_ready_i  <= 1'($random(seed));
    end

    always @(posedge ref_clk_i)
    begin
        if (rst_i)
            ri = 0;
        else
        begin
            if (qos_valid_o && qos_ready_i)
                chk_beat(exp_q[qos_flow_o].size() > 0 ? {qos_flow_o, exp_q[qos_flow_o].pop_front()} : 11'h7ff,
                         {qos_flow_o, qos_last_o, qos_data_o});
            if (rx_valid_o && rx_ready_i)
                chk_beat(uq.size() > 0 ? uq.pop_front() : 11'h7ff, {rx_flow_o, rx_last_o, rx_data_o});
            if (fmt_sel != FMT_STREAM && link.ds_valid && link.ds_ready)
                chk_byte({6'h00, FLOW_RSVD}, {6'h00, link.ds_beat.flow});
            if (jv)
                chk_grp({1'b1, jq.size() > 0 ? jq.pop_front() : 32'h0000_0000}, {mcast_join_o, mcast_group_o});
            jv = join_valid_i;
            if (rf_valid_o && rf_ready_i)
            begin
                if (ri == 1)
                    dslot = (rf_data_o != NULL_B1) && (rq.size() > 1);
                if (ri == 1 && dslot)
                    void'(rq.pop_front());
                if (ri == 0)
                    chk_byte(NULL_B0, rf_data_o);
                else if (dslot)
                    chk_byte(rq.pop_front(), rf_data_o);
                else
                    chk_byte(ri == 1 ? NULL_B1 : ri == 2 ? NULL_B2 : ri == 3 ? NULL_B3 : NULL_FILL, rf_data_o);
                ri = (ri == 187) ? 0 : ri + 1;
            end
        end
    end

    initial
    begin
        repeat (80000) @(posedge ref_clk_i);
        n_fail++;
        $display("[FAIL] %0t watchdog expired", $time);
        test_done();
    end

    initial
    begin
        @(posedge ref_clk_i);
        do_reset(FMT_STREAM);
        sync_ts_i <= 32'($random(seed));
        jg = 32'($random(seed));
        fork
            begin
                tunnel(2'h0, 12, 32'h0000_0021, 32'h0000_0810);
                tunnel(2'h1, 6, 32'h0000_0001, 32'h0000_0000);
                tunnel(2'h2, 32, 32'h0000_0001, 32'h8000_0000);
                tunnel(2'h1, 4, 32'h0000_0000, 32'h0000_0008);
                tunnel(2'h3, 1, 32'h0000_0001, 32'h0000_0001);
            end
            for (int i = 0; i < 8; i++) us_send(8'($random(seed)), 2'(i), (i % 4) == 3);
            begin
                join_valid_i <= 1'b1;
                join_group_i <= jg;
                jq.push_back(jg);
                @(posedge ref_clk_i);
                join_valid_i <= 1'b0;
            end
        join
        drain();
        // Timestamp held still so the patched bytes are known up front
        do_reset(FMT_MPEG);
        ts = 32'($random(seed));
        sync_ts_i <= ts;
        for (int i = 0; i < 188; i++)
        begin
            b = (i == 0) ? 8'h47 : (i == 1) ? 8'h01 : (i >= 10 && i < 16) ? SYNC_DA[8*(15-i) +: 8]
                : 8'($random(seed)) & 8'h7f;
            pay.push_back(b);
            rq.push_back((i >= 29 && i < 33) ? ts[8*(32-i) +: 8] : b);
        end
        fork
            begin
                tunnel(2'($random(seed)), 94, 32'h0000_0000, 32'h0000_0000);
                tunnel(2'($random(seed)), 94, 32'h0000_0000, 32'h0000_0000);
            end
            for (int i = 0; i < 3; i++) us_send(8'($random(seed)), 2'h3, 1'b1);
        join
        drain();
        test_done();
    end
endmodule : test_rpd_downstream_pseudowire_path
